// *** verilog/ufc_flow_cfg.sv ***
// UART flow-control, divisor and FIFO-level configuration block with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
module ufc_flow_cfg (
  input wire logic i_clk, // System clock, 20 MHz
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic [7:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI write strobes
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  output logic [1:0] o_bresp, // AXI write response
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  input wire logic [7:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready, // AXI read data ready
  input wire logic i_cts_n, // CTS pin, asynchronous
  input wire ufc_pkg::ufc_rx_char_t i_rx_char, // Character from receive engine
  input wire logic [6:0] i_tx_fifo_count, // Characters held in transmit FIFO
  input wire logic [6:0] i_rx_fifo_count, // Characters held in receive FIFO
  output ufc_pkg::ufc_rx_char_t o_rx_store, // Character to push into receive FIFO
  output logic o_tx_allow, // Transmitter may start a character
  output logic o_rts_n, // RTS pin level
  output logic [3:0] o_sw_flow_sel, // Software flow combination select
  output logic [15:0] o_baud_divisor, // Divisor for baud generator
  output ufc_pkg::ufc_trig_t o_trig, // Effective interrupt trigger levels
  output logic o_irq // Level interrupt, high while unmasked status set
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] efc_r, div_lo_r, div_hi_r, thr_r, trg_r, ier_r, fcr_r, mcr_r, second_xoff_char_r;
  logic [ufc_pkg::IRQ_W-1:0] stat_r, mask_r;
  logic cts_m_r, cts_s_r;
  logic rts_halt_r, tx_allow_r, rts_n_r;
  logic rx_hit_r, tx_hit_r;
  ufc_pkg::ufc_rx_char_t rx_store_r;
  ufc_pkg::ufc_trig_t trig_r;
  logic [7:0] aw_addr_r, ar_addr_r;
  logic [7:0] w_data_r;
  logic w_strb_r, aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ************************************************************
  // Write decode
  // ************************************************************
  wire enh_en = efc_r[ufc_pkg::EFC_ENH_EN];
  wire thr_sel = enh_en & mcr_r[ufc_pkg::MCR_THR_SEL];
  wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_en = wr_go & w_strb_r;
  wire wr_efc = wr_en & (aw_addr_r == ufc_pkg::OFF_ENH_FEAT);
  wire div_open = ~ier_r[ufc_pkg::IER_SLEEP];
  wire wr_dlo = wr_en & (aw_addr_r == ufc_pkg::OFF_DIV_LOW) & div_open;
  wire wr_dhi = wr_en & (aw_addr_r == ufc_pkg::OFF_DIV_HIGH) & div_open;
  wire wr_thr = wr_en & (aw_addr_r == ufc_pkg::OFF_FLOW_THR) & thr_sel;
  wire wr_trg = wr_en & (aw_addr_r == ufc_pkg::OFF_TRIG_LVL) & thr_sel;
  wire wr_ier = wr_en & (aw_addr_r == ufc_pkg::OFF_INT_EN);
  wire wr_fcr = wr_en & (aw_addr_r == ufc_pkg::OFF_FIFO_CTL);
  wire wr_mcr = wr_en & (aw_addr_r == ufc_pkg::OFF_MODEM_CTL);
  wire wr_xof = wr_en & (aw_addr_r == ufc_pkg::OFF_SECOND_XOFF_CHAR);
  wire wr_sts = wr_en & (aw_addr_r == ufc_pkg::OFF_IRQ_STAT);
  wire wr_msk = wr_en & (aw_addr_r == ufc_pkg::OFF_IRQ_MASK);
  wire wr_map = (aw_addr_r <= ufc_pkg::OFF_INT_ID) & (aw_addr_r[1:0] == 2'h0);
  wire [7:0] ier_nxt = ufc_pkg::gated_merge(ier_r, w_data_r, ufc_pkg::IER_GATED, enh_en);
  wire [7:0] fcr_nxt = ufc_pkg::gated_merge(fcr_r, w_data_r, ufc_pkg::FCR_GATED, enh_en);
  wire [7:0] mcr_nxt = ufc_pkg::gated_merge(mcr_r, w_data_r, ufc_pkg::MCR_GATED, enh_en);

  // ************************************************************
  // Levels, thresholds and events
  // ************************************************************
  wire [6:0] tx_space = ufc_pkg::FIFO_DEPTH - i_tx_fifo_count;
  wire [3:0] halt_nib = thr_r[ufc_pkg::NIB_LO +: ufc_pkg::NIB_W];
  wire [3:0] resume_nib = thr_r[ufc_pkg::NIB_HI +: ufc_pkg::NIB_W];
  wire [6:0] halt_lvl = {1'b0, halt_nib, 2'h0};
  wire [6:0] resume_lvl = {1'b0, resume_nib, 2'h0};
  wire [3:0] trg_rx_nib = trg_r[ufc_pkg::NIB_HI +: ufc_pkg::NIB_W];
  wire [3:0] trg_tx_nib = trg_r[ufc_pkg::NIB_LO +: ufc_pkg::NIB_W];
  wire [1:0] fcr_rx_sel = fcr_r[ufc_pkg::FCR_RX_SEL +: 2];
  wire [1:0] fcr_tx_sel = fcr_r[ufc_pkg::FCR_TX_SEL +: 2];
  wire [6:0] rx_fcr_lvl = (fcr_rx_sel == 2'h0) ? ufc_pkg::RX_SEL_LVL0 :
                          (fcr_rx_sel == 2'h1) ? ufc_pkg::RX_SEL_LVL1 :
                          (fcr_rx_sel == 2'h2) ? ufc_pkg::RX_SEL_LVL2 : ufc_pkg::RX_SEL_LVL3;
  wire [6:0] tx_fcr_lvl = (fcr_tx_sel == 2'h0) ? ufc_pkg::TX_SEL_LVL0 :
                          (fcr_tx_sel == 2'h1) ? ufc_pkg::TX_SEL_LVL1 :
                          (fcr_tx_sel == 2'h2) ? ufc_pkg::TX_SEL_LVL2 : ufc_pkg::TX_SEL_LVL3;
  wire [6:0] rx_trig = (trg_rx_nib != 4'h0) ? {1'b0, trg_rx_nib, 2'h0} : rx_fcr_lvl;
  wire [6:0] tx_trig = (trg_tx_nib != 4'h0) ? {1'b0, trg_tx_nib, 2'h0} : tx_fcr_lvl;
  wire rx_hit = i_rx_fifo_count >= trig_r.rx_level;
  wire tx_hit = tx_space >= trig_r.tx_level;
  // Halt/resume hysteresis; with a badly ordered pair halt wins wherever both levels are met, nothing checks it
  wire rts_set = efc_r[ufc_pkg::EFC_RTS_EN] & (i_rx_fifo_count >= halt_lvl);
  wire rts_clr = i_rx_fifo_count <= resume_lvl;
  wire rts_halt_nxt = ~efc_r[ufc_pkg::EFC_RTS_EN] ? 1'b0 : rts_set ? 1'b1 : rts_clr ? 1'b0 : rts_halt_r;
  wire rts_n_nxt = efc_r[ufc_pkg::EFC_RTS_EN] ? rts_halt_nxt : ~mcr_r[ufc_pkg::MCR_RTS_FORCE];
  wire tx_allow_nxt = ~(efc_r[ufc_pkg::EFC_CTS_EN] & cts_s_r);
  wire spec_hit = i_rx_char.valid & efc_r[ufc_pkg::EFC_SPEC_EN] & (i_rx_char.data == second_xoff_char_r);
  wire [ufc_pkg::IRQ_W-1:0] ev_set;
  assign ev_set[ufc_pkg::IRQ_SPEC] = spec_hit;
  assign ev_set[ufc_pkg::IRQ_RX_TRIG] = rx_hit & ~rx_hit_r;
  assign ev_set[ufc_pkg::IRQ_TX_TRIG] = tx_hit & ~tx_hit_r;
  assign ev_set[ufc_pkg::IRQ_RTS_HALT] = rts_halt_nxt & ~rts_halt_r;
  wire [ufc_pkg::IRQ_W-1:0] w1c = wr_sts ? w_data_r[ufc_pkg::IRQ_W-1:0] : '0;
  // Set beats clear so an event in the clearing cycle survives
  wire [ufc_pkg::IRQ_W-1:0] stat_nxt = ev_set | (stat_r & ~w1c);

  // ************************************************************
  // Read decode
  // ************************************************************
  wire [7:0] int_id = {2'h0, 1'b0, stat_r[ufc_pkg::IRQ_SPEC], 3'h0, ~o_irq};
  wire [7:0] rd_byte =
    (ar_addr_r == ufc_pkg::OFF_ENH_FEAT) ? efc_r :
    (ar_addr_r == ufc_pkg::OFF_DIV_LOW) ? div_lo_r :
    (ar_addr_r == ufc_pkg::OFF_DIV_HIGH) ? div_hi_r :
    (ar_addr_r == ufc_pkg::OFF_FLOW_THR) ? thr_r :
    (ar_addr_r == ufc_pkg::OFF_TRIG_LVL) ? trg_r :
    (ar_addr_r == ufc_pkg::OFF_TX_SPACE) ? {1'b0, tx_space} :
    (ar_addr_r == ufc_pkg::OFF_RX_FILL) ? {1'b0, i_rx_fifo_count} :
    (ar_addr_r == ufc_pkg::OFF_INT_EN) ? ier_r :
    (ar_addr_r == ufc_pkg::OFF_FIFO_CTL) ? fcr_r :
    (ar_addr_r == ufc_pkg::OFF_MODEM_CTL) ? mcr_r :
    (ar_addr_r == ufc_pkg::OFF_SECOND_XOFF_CHAR) ? second_xoff_char_r :
    (ar_addr_r == ufc_pkg::OFF_IRQ_STAT) ? {4'h0, stat_r} :
    (ar_addr_r == ufc_pkg::OFF_IRQ_MASK) ? {4'h0, mask_r} :
    (ar_addr_r == ufc_pkg::OFF_INT_ID) ? int_id : 8'h00;
  wire rd_map = (ar_addr_r <= ufc_pkg::OFF_INT_ID) & (ar_addr_r[1:0] == 2'h0);
  logic ar_held_r;
  wire rd_go = ar_held_r & ~rvalid_r;

  // ************************************************************
  // AXI4-Lite channel handshakes
  // ************************************************************
  assign o_awready = ~aw_held_r;
  assign o_wready = ~w_held_r;
  assign o_arready = ~ar_held_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rresp = rresp_r;
  assign o_rdata = rdata_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= ufc_pkg::REG_RST;
    end else if (i_awvalid && o_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= i_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      w_held_r <= 1'b0;
      w_data_r <= ufc_pkg::REG_RST;
      w_strb_r <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= i_wdata[7:0];
      w_strb_r <= i_wstrb[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= ufc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_map ? ufc_pkg::RESP_OKAY : ufc_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ar_held_r <= 1'b0;
      ar_addr_r <= ufc_pkg::REG_RST;
    end else if (i_arvalid && o_arready) begin
      ar_held_r <= 1'b1;
      ar_addr_r <= i_araddr;
    end else if (rd_go) begin
      ar_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rvalid_r <= 1'b0;
      rresp_r <= ufc_pkg::RESP_OKAY;
      rdata_r <= '0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_map ? ufc_pkg::RESP_OKAY : ufc_pkg::RESP_SLVERR;
      rdata_r <= {24'h0, rd_byte};
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      efc_r <= ufc_pkg::REG_RST;
      div_lo_r <= ufc_pkg::REG_RST;
      div_hi_r <= ufc_pkg::REG_RST;
      thr_r <= ufc_pkg::REG_RST;
      trg_r <= ufc_pkg::REG_RST;
    end else begin
      if (wr_efc) efc_r <= w_data_r;
      if (wr_dlo) div_lo_r <= w_data_r;
      if (wr_dhi) div_hi_r <= w_data_r;
      if (wr_thr) thr_r <= w_data_r;
      if (wr_trg) trg_r <= w_data_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ier_r <= ufc_pkg::REG_RST;
      fcr_r <= ufc_pkg::REG_RST;
      mcr_r <= ufc_pkg::REG_RST;
      second_xoff_char_r <= ufc_pkg::REG_RST;
      mask_r <= '0;
    end else begin
      if (wr_ier) ier_r <= ier_nxt;
      if (wr_fcr) fcr_r <= fcr_nxt;
      if (wr_mcr) mcr_r <= mcr_nxt;
      if (wr_xof) second_xoff_char_r <= w_data_r;
      if (wr_msk) mask_r <= w_data_r[ufc_pkg::IRQ_W-1:0];
    end
  end

  // ************************************************************
  // Line side and status
  // ************************************************************
  // CTS pin is asynchronous; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cts_m_r <= 1'b1;
      cts_s_r <= 1'b1;
    end else begin
      cts_m_r <= i_cts_n;
      cts_s_r <= cts_m_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_allow_r <= 1'b1;
      rts_halt_r <= 1'b0;
      rts_n_r <= 1'b1;
      rx_hit_r <= 1'b0;
      tx_hit_r <= 1'b0;
      stat_r <= '0;
      rx_store_r <= '0;
      trig_r <= '0;
    end else begin
      tx_allow_r <= tx_allow_nxt;
      rts_halt_r <= rts_halt_nxt;
      rts_n_r <= rts_n_nxt;
      rx_hit_r <= rx_hit;
      tx_hit_r <= tx_hit;
      stat_r <= stat_nxt;
      rx_store_r <= i_rx_char;
      trig_r <= '{rx_level: rx_trig, tx_level: tx_trig};
    end
  end

  assign o_tx_allow = tx_allow_r;
  assign o_rts_n = rts_n_r;
  assign o_rx_store = rx_store_r;
  assign o_trig = trig_r;
  assign o_sw_flow_sel = efc_r[ufc_pkg::NIB_LO +: ufc_pkg::NIB_W];
  assign o_baud_divisor = {div_hi_r, div_lo_r};
  assign o_irq = |(stat_r & mask_r);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_cts_high_held;
    (efc_r[ufc_pkg::EFC_CTS_EN] && i_cts_n) [*3];
  endsequence
  sequence s_rx_match;
    i_rx_char.valid && efc_r[ufc_pkg::EFC_SPEC_EN] && (i_rx_char.data == second_xoff_char_r);
  endsequence

  a_cts_stop_tx: assert property (s_cts_high_held |=> !o_tx_allow)
    else $error("Transmit allowed while CTS high and CTS flow on");
  a_rts_halt_hit: assert property (efc_r[ufc_pkg::EFC_RTS_EN] && (i_rx_fifo_count >= halt_lvl) |=> o_rts_n)
    else $error("RTS not raised at halt level");
  a_spec_char_flag: assert property (s_rx_match |=> stat_r[ufc_pkg::IRQ_SPEC] && o_rx_store.valid)
    else $error("Special character not flagged or not stored");
  a_ier_gated_wr: assert property (wr_ier && !enh_en |=> ier_r[7:4] == $past(ier_r[7:4]))
    else $error("Gated interrupt-enable bits changed");
  a_div_sleep_lock: assert property (ier_r[ufc_pkg::IER_SLEEP] |=> $stable(o_baud_divisor))
    else $error("Divisor changed in sleep mode");
  a_thr_gated_wr: assert property (!thr_sel |=> $stable(thr_r))
    else $error("Threshold register written without selection");
  a_trg_gated_wr: assert property (!thr_sel |=> $stable(trg_r))
    else $error("Trigger register written without selection");
  a_trig_fallback: assert property (trg_rx_nib == 4'h0 && $stable(fcr_r) && $stable(trg_r)
                                    |=> o_trig.rx_level == $past(rx_fcr_lvl))
    else $error("Zero nibble did not fall back to FIFO control level");
  a_tx_space_rd: assert property (rd_go && ar_addr_r == ufc_pkg::OFF_TX_SPACE
                                  |=> o_rdata[7:0] == 8'h40 - {1'b0, $past(i_tx_fifo_count)})
    else $error("Transmit space read wrong");
  a_rx_fill_rd: assert property (rd_go && ar_addr_r == ufc_pkg::OFF_RX_FILL
                                 |=> o_rdata[7:0] == {1'b0, $past(i_rx_fifo_count)})
    else $error("Receive fill read wrong");
  a_mcr_gated_wr: assert property (wr_mcr && !enh_en |=> mcr_r[7:5] == $past(mcr_r[7:5]))
    else $error("Gated modem-control bits changed");
  a_reset_flows_off: assert property ($past(i_sys_rst) |-> efc_r[7:5] == 3'h0)
    else $error("Flow enables not clear after reset");
endmodule // ufc_flow_cfg
`default_nettype wire

// *** shared/ufc_pkg.sv ***
// Package: register map, field positions and carrier types of the UART flow/level config block
`default_nettype none
package ufc_pkg;
  // ************************************************************
  // Register byte addresses (one aligned word each)
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_ENH_FEAT = 8'h00;
  localparam logic [7:0] OFF_DIV_LOW = 8'h04;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h08;
  localparam logic [7:0] OFF_FLOW_THR = 8'h0c;
  localparam logic [7:0] OFF_TRIG_LVL = 8'h10;
  localparam logic [7:0] OFF_TX_SPACE = 8'h14;
  localparam logic [7:0] OFF_RX_FILL = 8'h18;
  localparam logic [7:0] OFF_INT_EN = 8'h1c;
  localparam logic [7:0] OFF_FIFO_CTL = 8'h20;
  localparam logic [7:0] OFF_MODEM_CTL = 8'h24;
  localparam logic [7:0] OFF_SECOND_XOFF_CHAR = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h2c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_INT_ID = 8'h34;

  // ************************************************************
  // Field positions and masks
  // ************************************************************
  localparam int unsigned EFC_CTS_EN = 7;
  localparam int unsigned EFC_RTS_EN = 6;
  localparam int unsigned EFC_SPEC_EN = 5;
  localparam int unsigned EFC_ENH_EN = 4;
  localparam int unsigned IER_SLEEP = 4;
  localparam int unsigned MCR_THR_SEL = 2;
  localparam int unsigned MCR_RTS_FORCE = 1;
  localparam int unsigned IID_SPEC = 4;
  localparam int unsigned IID_NONE = 0;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned NIB_LO = 0;
  localparam int unsigned NIB_HI = 4;
  localparam int unsigned FCR_RX_SEL = 6;
  localparam int unsigned FCR_TX_SEL = 4;
  localparam int unsigned LVL_W = 7;
  localparam int unsigned LVL_STEP_SH = 2;
  localparam logic [7:0] IER_GATED = 8'hf0;
  localparam logic [7:0] FCR_GATED = 8'h30;
  localparam logic [7:0] MCR_GATED = 8'he4;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;

  // Fallback trigger levels chosen by the FIFO control selector fields
  localparam logic [6:0] RX_SEL_LVL0 = 7'h08;
  localparam logic [6:0] RX_SEL_LVL1 = 7'h10;
  localparam logic [6:0] RX_SEL_LVL2 = 7'h38;
  localparam logic [6:0] RX_SEL_LVL3 = 7'h3c;
  localparam logic [6:0] TX_SEL_LVL0 = 7'h08;
  localparam logic [6:0] TX_SEL_LVL1 = 7'h10;
  localparam logic [6:0] TX_SEL_LVL2 = 7'h20;
  localparam logic [6:0] TX_SEL_LVL3 = 7'h38;

  // Sticky interrupt status bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_SPEC = 0;
  localparam int unsigned IRQ_RX_TRIG = 1;
  localparam int unsigned IRQ_TX_TRIG = 2;
  localparam int unsigned IRQ_RTS_HALT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufc_rx_char_t;

  typedef struct packed {
    logic [6:0] rx_level;
    logic [6:0] tx_level;
  } ufc_trig_t;

  // Keep gated bits unless the enhanced enable is set
  function automatic logic [7:0] gated_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] gmask, input logic enh);
    gated_merge = (new_v & ~gmask) | ((enh ? new_v : old_v) & gmask);
  endfunction
endpackage
`default_nettype wire

// *** tb/ufc_remote_model.sv ***
// Remote serial device model: drives the CTS pin and delivers received characters
`default_nettype none
module ufc_remote_model (
  input wire logic i_clk, // Clock
  input wire logic i_cts_hold, // Ask the device to pause sending
  input wire logic i_send, // Deliver one character
  input wire logic [7:0] i_char, // Character to deliver
  output logic o_cts_n, // CTS pin, high pauses the device
  output ufc_pkg::ufc_rx_char_t o_rx_char // Received character
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cts_n = 1'b0;
    o_rx_char = '0;
  end
  always @(posedge i_clk) begin
    o_cts_n <= i_cts_hold;
    o_rx_char.valid <= i_send;
    // Idle data keeps changing so a stale character can never pass a compare
    o_rx_char.data <= i_send ? i_char : ~o_rx_char.data;
  end
endmodule // ufc_remote_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench: register, flow-control and level tests of the UART flow/level config block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, ch = 8'h00, a, b;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'h0;
  logic [6:0] txc = 7'h00, rxc = 7'h00, t, r;
  logic cts_hold = 1'b0, send = 1'b0;
  logic [1:0] rs, bs;
  wire awr, wr_, bv, arr, rv, cts_n, tx_allow, rts_n, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] swsel;
  wire [15:0] div;
  wire ufc_pkg::ufc_rx_char_t rxch, store;
  wire ufc_pkg::ufc_trig_t trig;
  int fail_count = 0, total_checks = 0, cyc = 0;
  logic [6:0] rv_tab [5] = '{7'h08, 7'h27, 7'h28, 7'h14, 7'h08};
  logic ev_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  ufc_flow_cfg u_ufc_flow_cfg (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr_), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(bry), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rv), .i_rready(rry), .i_cts_n(cts_n), .i_rx_char(rxch), .i_tx_fifo_count(txc),
    .i_rx_fifo_count(rxc), .o_rx_store(store), .o_tx_allow(tx_allow), .o_rts_n(rts_n), .o_sw_flow_sel(swsel),
    .o_baud_divisor(div), .o_trig(trig), .o_irq(irq));
  ufc_remote_model u_ufc_remote_model (.i_clk(i_clk), .i_cts_hold(cts_hold), .i_send(send), .i_char(ch),
    .o_cts_n(cts_n), .o_rx_char(rxch));

  initial begin
    forever #25 i_clk = ~i_clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Handshakes are sampled at the falling edge, where they equal what the next rising edge sees
  task automatic axi_wr(input logic [7:0] ad, input logic [7:0] d);
    logic aw_t, w_t, b_t;
    @(posedge i_clk);
    awa <= ad; wd <= {24'h0, d}; ws <= 4'h1; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do begin
      @(negedge i_clk);
      aw_t = awv & awr; w_t = wv & wr_; b_t = bv;
      bs = bresp;
      @(posedge i_clk);
      if (aw_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
    end while (b_t !== 1'b1);
    bry <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    logic ar_t, r_t;
    @(posedge i_clk);
    ara <= ad; arv <= 1'b1; rry <= 1'b1;
    do begin
      @(negedge i_clk);
      ar_t = arv & arr; r_t = rv; rd = rdata; rs = rresp;
      @(posedge i_clk);
      if (ar_t) arv <= 1'b0;
    end while (r_t !== 1'b1);
    rry <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    axi_rd(ad);
    chk({rs, rd[29:0]}, {ufc_pkg::RESP_OKAY, 22'h0, e});
  endtask
  task automatic send_char(input logic [7:0] c);
    @(posedge i_clk); ch <= c; send <= 1'b1;
    @(posedge i_clk); send <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  function automatic logic [6:0] fcr_rx(input logic [1:0] s);
    fcr_rx = s == 0 ? ufc_pkg::RX_SEL_LVL0 : s == 1 ? ufc_pkg::RX_SEL_LVL1 : s == 2 ? ufc_pkg::RX_SEL_LVL2 : ufc_pkg::RX_SEL_LVL3;
  endfunction
  function automatic logic [6:0] fcr_tx(input logic [1:0] s);
    fcr_tx = s == 0 ? ufc_pkg::TX_SEL_LVL0 : s == 1 ? ufc_pkg::TX_SEL_LVL1 : s == 2 ? ufc_pkg::TX_SEL_LVL2 : ufc_pkg::TX_SEL_LVL3;
  endfunction
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(12));
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd_chk(ufc_pkg::OFF_ENH_FEAT, 8'h00);
    chk({rts_n, tx_allow, trig}, {2'b11, ufc_pkg::RX_SEL_LVL0, ufc_pkg::TX_SEL_LVL0});
    axi_wr(ufc_pkg::OFF_MODEM_CTL, 8'he4); axi_wr(ufc_pkg::OFF_INT_EN, 8'hf0); axi_wr(ufc_pkg::OFF_FIFO_CTL, 8'h30);
    rd_chk(ufc_pkg::OFF_MODEM_CTL, 8'h00);
    rd_chk(ufc_pkg::OFF_INT_EN, 8'h00);
    rd_chk(ufc_pkg::OFF_FIFO_CTL, 8'h00);
    axi_wr(ufc_pkg::OFF_ENH_FEAT, 8'h10); axi_wr(ufc_pkg::OFF_FLOW_THR, 8'h2a); axi_wr(ufc_pkg::OFF_TRIG_LVL, 8'h11);
    rd_chk(ufc_pkg::OFF_FLOW_THR, 8'h00);
    rd_chk(ufc_pkg::OFF_TRIG_LVL, 8'h00);
    axi_wr(ufc_pkg::OFF_MODEM_CTL, 8'h04);
    chk(bs, ufc_pkg::RESP_OKAY);
    rd_chk(ufc_pkg::OFF_MODEM_CTL, 8'h04);
    axi_wr(ufc_pkg::OFF_FLOW_THR, 8'h2a);
    rd_chk(ufc_pkg::OFF_FLOW_THR, 8'h2a);
    for (int s = 0; s < 4; s++) begin
      b = 8'($urandom_range(15, 1));
      axi_wr(ufc_pkg::OFF_FIFO_CTL, {s[1:0], s[1:0], 4'h0}); axi_wr(ufc_pkg::OFF_TRIG_LVL, {4'h0, b[3:0]});
      chk(trig, {fcr_rx(s[1:0]), b[4:0], 2'b00});
      axi_wr(ufc_pkg::OFF_FIFO_CTL, {2'b00, s[1:0], 4'h0}); axi_wr(ufc_pkg::OFF_TRIG_LVL, {b[3:0], 4'h0});
      chk(trig, {b[4:0], 2'b00, fcr_tx(s[1:0])});
    end
    for (int i = 0; i < 4; i++) begin
      t = i == 0 ? 7'h00 : i == 1 ? 7'h40 : 7'($urandom_range(64, 0));
      r = i == 0 ? 7'h40 : i == 1 ? 7'h00 : 7'($urandom_range(64, 0));
      @(posedge i_clk); txc <= t; rxc <= r;
      rd_chk(ufc_pkg::OFF_TX_SPACE, 8'(7'h40 - t));
      rd_chk(ufc_pkg::OFF_RX_FILL, {1'b0, r});
    end
    b = 8'($urandom_range(15, 0));
    axi_wr(ufc_pkg::OFF_ENH_FEAT, {4'hf, b[3:0]});
    chk(swsel, b[3:0]);
    for (int k = 0; k < 5; k++) begin
      @(posedge i_clk); rxc <= rv_tab[k];
      repeat (2) @(posedge i_clk);
      @(negedge i_clk); chk(rts_n, ev_tab[k]);
    end
    for (int k = 1; k >= 0; k--) begin
      @(posedge i_clk); cts_hold <= k[0];
      repeat (5) @(posedge i_clk);
      @(negedge i_clk); chk(tx_allow, !k[0]);
    end
    a = 8'($urandom());
    axi_wr(ufc_pkg::OFF_SECOND_XOFF_CHAR, a); axi_wr(ufc_pkg::OFF_IRQ_MASK, 8'h01);
    send_char(a ^ 8'h01);
    chk({store, irq}, {1'b1, a ^ 8'h01, 1'b0});
    send_char(a);
    chk({store, irq}, {1'b1, a, 1'b1});
    rd_chk(ufc_pkg::OFF_INT_ID, 8'h10);
    axi_wr(ufc_pkg::OFF_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    a = 8'($urandom()); b = 8'($urandom());
    axi_wr(ufc_pkg::OFF_DIV_LOW, a); axi_wr(ufc_pkg::OFF_DIV_HIGH, b);
    chk(div, {b, a});
    axi_wr(ufc_pkg::OFF_INT_EN, 8'h10); axi_wr(ufc_pkg::OFF_DIV_LOW, ~a); axi_wr(ufc_pkg::OFF_DIV_HIGH, ~b);
    chk(div, {b, a});
    axi_wr(8'h38, 8'h00);
    chk(bs, ufc_pkg::RESP_SLVERR);
    axi_rd(8'h38);
    chk(rs, ufc_pkg::RESP_SLVERR);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
